// [hw/wmdu_pkg.sv]
// Constants, types and register map of the wide multiply/divide unit.
// Assumes an 8-bit core that decodes its own instructions and owns A, B and PSW.
// Behaviour
// - Both selects zero give classic 8-bit operations
// - 8-bit mode matches classic results and flags
// - 16x16 product into ext_b,B,A,ext_acc; OV upper
// - 16x16 multiply takes 16 clock cycles
// - 16/16 quotient A,ext_acc; remainder B,ext_b
// - 16/16 divide takes 16 clock cycles
// - 32/16 quotient A..ext_acc3; remainder B,ext_b
// - 32/16 divide takes 32 clock cycles
// - Long-divide bit 3 only counts in wide mode
// - Wide-mode bit 0 selects operand width
// - Same multiply and divide opcodes for all widths
package wmdu_pkg;

  localparam logic [7:0] ADDR_EXT_ACC2 = 8'hCE;
  localparam logic [7:0] ADDR_EXT_ACC3 = 8'hCF;
  localparam logic [7:0] ADDR_EXT_ACC = 8'hE6;
  localparam logic [7:0] ADDR_EXT_B = 8'hE7;
  localparam logic [7:0] ADDR_AUX_CTRL = 8'hF7;

  localparam logic [7:0] RST_EXT_ACC2 = 8'h00;
  localparam logic [7:0] RST_EXT_ACC3 = 8'h00;
  localparam logic [7:0] RST_EXT_ACC = 8'h00;
  localparam logic [7:0] RST_EXT_B = 8'h00;
  localparam logic [7:0] RST_AUX_CTRL = 8'h00;

  localparam int BIT_WIDE_MODE = 0;
  localparam int BIT_LONG_DIV = 3;

  localparam logic [7:0] OPC_MUL = 8'hA4;
  localparam logic [7:0] OPC_DIV = 8'h84;

  localparam logic [5:0] STEPS_8 = 6'h08;
  localparam logic [5:0] STEPS_16 = 6'h10;
  localparam logic [5:0] STEPS_32 = 6'h20;

  typedef enum logic [1:0]
  {
    WMDU_IDLE = 2'b00,
    WMDU_RUN = 2'b01,
    WMDU_DONE = 2'b11
  } wmdu_state_type;

endpackage

// [hw/wmdu_engine.sv]
// Iterative shift-add multiplier and restoring divider, one bit per step.
// Assumes the caller loads operands, then issues one step per enabled cycle.
`timescale 1ns/1ps
`default_nettype none
module wmdu_engine
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic step,
  input wire logic is_div,
  input wire logic [15:0] operand,
  input wire logic [31:0] load_val,
  output logic [16:0] rem_r,
  output logic [31:0] quo_r
);
  import wmdu_pkg::*;

  wire [16:0] add_sum;
  wire [16:0] div_trial;
  wire div_fits;
  wire [16:0] div_left;
  wire [16:0] rem_nxt;
  wire [31:0] quo_nxt;

  // Multiply: add multiplicand when low bit set, shift pair right
  assign add_sum = {1'b0, rem_r[15:0]} + (quo_r[0] ? {1'b0, operand} : 17'h00000);
  // Divide: shift in next dividend bit, subtract when it fits
  assign div_trial = {rem_r[15:0], quo_r[31]};
  assign div_fits = div_trial >= {1'b0, operand};
  assign div_left = div_trial - {1'b0, operand};
  assign rem_nxt = is_div ? (div_fits ? div_left : div_trial) : {1'b0, add_sum[16:1]};
  assign quo_nxt = is_div ? {quo_r[30:0], div_fits} :
    {16'h0000, add_sum[0], quo_r[15:1]};

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rem_r <= 17'h00000;
      quo_r <= 32'h00000000;
    end
    else if (ce && load)
    begin
      rem_r <= 17'h00000;
      quo_r <= load_val;
    end
    else if (ce && step)
    begin
      rem_r <= rem_nxt;
      quo_r <= quo_nxt;
    end
  end

endmodule
`default_nettype wire

// [hw/wmdu_top.sv]
// Wide multiply/divide unit with its expansion registers on the core's SFR port.
// Assumes the core offers each fetched opcode with A and B, and honours stall.
`timescale 1ns/1ps
`default_nettype none
module wmdu_top
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] b_in,
  output logic [7:0] acc_out,
  output logic [7:0] b_out,
  output logic ov_out,
  output logic result_wr,
  output logic stall
);
  import wmdu_pkg::*;

  wmdu_state_type state_r;
  wmdu_state_type state_nxt;
  logic [7:0] ext_acc_r;
  logic [7:0] ext_acc2_r;
  logic [7:0] ext_acc3_r;
  logic [7:0] ext_b_r;
  logic [7:0] aux_ctrl_r;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic op_mul_r;
  logic wide_r;
  logic long_r;
  logic [7:0] sfr_rdata_r;
  logic [7:0] acc_out_r;
  logic [7:0] b_out_r;
  logic ov_r;
  logic result_wr_r;
  logic stall_r;
  logic [16:0] eng_rem;
  logic [31:0] eng_quo;
  logic divisor_zero_r;
  logic [15:0] operand_r;

  // Step count for the selected width and operation
  function automatic logic [5:0] step_count(input logic wide, input logic long_sel,
                                            input logic is_mul);
    logic [5:0] n;
    n = STEPS_8;
    if (wide)
    begin
      n = (long_sel && !is_mul) ? STEPS_32 : STEPS_16;
    end
    return n;
  endfunction

  wire take_mul;
  wire take_div;
  wire take;
  wire cfg_wide;
  wire cfg_long;
  wire [15:0] eng_operand;
  wire [31:0] eng_load;
  wire [31:0] mul_load;
  wire [31:0] div_load;
  wire last_step;
  wire finish;
  wire sfr_write_ok;
  wire [15:0] prod8;
  wire [31:0] prod16;
  wire [7:0] res_acc;
  wire [7:0] res_b;
  wire res_ov;

  // Only the two classic opcodes start the unit, at every width
  assign take_mul = op_valid && (op_code == OPC_MUL);
  assign take_div = op_valid && (op_code == OPC_DIV);
  assign take = (state_r == WMDU_IDLE) && (take_mul || take_div);

  // Long-divide select is masked unless wide mode is on
  assign cfg_wide = aux_ctrl_r[BIT_WIDE_MODE];
  assign cfg_long = aux_ctrl_r[BIT_WIDE_MODE] && aux_ctrl_r[BIT_LONG_DIV];

  // Operand selection per width
  assign eng_operand = cfg_wide ? {ext_b_r, b_in} : {8'h00, b_in};
  assign mul_load = cfg_wide ? {16'h0000, ext_acc_r, acc_in} : {24'h000000, b_in};
  assign div_load = cfg_long ? {ext_acc3_r, ext_acc2_r, ext_acc_r, acc_in} :
    (cfg_wide ? {ext_acc_r, acc_in, 16'h0000} : {acc_in, 24'h000000});
  assign eng_load = take_mul ? mul_load : div_load;
  // Classic multiply feeds A as multiplicand and B as multiplier
  wire [15:0] mul_operand;
  assign mul_operand = cfg_wide ? {ext_b_r, b_in} : {8'h00, acc_in};

  assign last_step = (state_r == WMDU_RUN) && (cnt_r == 6'h00);
  assign finish = (state_r == WMDU_DONE);

  // Result mapping
  assign prod8 = {eng_rem[7:0], eng_quo[15:8]};
  assign prod16 = {eng_rem[15:0], eng_quo[15:0]};
  assign res_acc = op_mul_r ? (wide_r ? prod16[15:8] : prod8[7:0]) :
    (long_r ? eng_quo[31:24] : (wide_r ? eng_quo[15:8] : eng_quo[7:0]));
  assign res_b = op_mul_r ? (wide_r ? prod16[23:16] : prod8[15:8]) :
    (wide_r ? eng_rem[15:8] : eng_rem[7:0]);
  assign res_ov = op_mul_r ? (wide_r ? (prod16[31:16] != 16'h0000) :
    (prod8[15:8] != 8'h00)) : (divisor_zero_r);

  // Expansion registers are not writable while the core is stalled
  assign sfr_write_ok = sfr_wr && (state_r == WMDU_IDLE) && !take;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      WMDU_IDLE:
      begin
        if (take)
        begin
          state_nxt = WMDU_RUN;
          cnt_nxt = step_count(cfg_wide, cfg_long, take_mul) - 6'h01;
        end
      end
      WMDU_RUN:
      begin
        if (last_step)
        begin
          state_nxt = WMDU_DONE;
        end
        else
        begin
          cnt_nxt = cnt_r - 6'h01;
        end
      end
      WMDU_DONE:
      begin
        state_nxt = WMDU_IDLE;
      end
      default:
      begin
        state_nxt = WMDU_IDLE;
        cnt_nxt = 6'h00;
      end
    endcase
  end

  wmdu_engine u_engine
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .load(take),
    .step(state_r == WMDU_RUN),
    .is_div(take ? take_div : !op_mul_r),
    .operand(take ? eng_operand : operand_r),
    .load_val(eng_load),
    .rem_r(eng_rem),
    .quo_r(eng_quo)
  );

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r <= WMDU_IDLE;
      cnt_r <= 6'h00;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Operation captured at start
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      op_mul_r <= 1'b0;
      wide_r <= 1'b0;
      long_r <= 1'b0;
      operand_r <= 16'h0000;
      divisor_zero_r <= 1'b0;
    end
    else if (ce && take)
    begin
      op_mul_r <= take_mul;
      wide_r <= cfg_wide;
      long_r <= cfg_long;
      operand_r <= take_mul ? mul_operand : eng_operand;
      divisor_zero_r <= (eng_operand == 16'h0000);
    end
  end

  // Expansion registers: software writes, result write-back wins when done
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ext_acc_r <= RST_EXT_ACC;
      ext_acc2_r <= RST_EXT_ACC2;
      ext_acc3_r <= RST_EXT_ACC3;
      ext_b_r <= RST_EXT_B;
      aux_ctrl_r <= RST_AUX_CTRL;
    end
    else if (ce && finish && wide_r)
    begin
      if (op_mul_r)
      begin
        ext_b_r <= prod16[31:24];
        ext_acc_r <= prod16[7:0];
      end
      else if (long_r)
      begin
        ext_acc_r <= eng_quo[23:16];
        ext_acc2_r <= eng_quo[15:8];
        ext_acc3_r <= eng_quo[7:0];
        ext_b_r <= eng_rem[7:0];
      end
      else
      begin
        ext_acc_r <= eng_quo[7:0];
        ext_b_r <= eng_rem[7:0];
      end
    end
    else if (ce && sfr_write_ok)
    begin
      if (sfr_addr == ADDR_EXT_ACC)
        ext_acc_r <= sfr_wdata;
      if (sfr_addr == ADDR_EXT_ACC2)
        ext_acc2_r <= sfr_wdata;
      if (sfr_addr == ADDR_EXT_ACC3)
        ext_acc3_r <= sfr_wdata;
      if (sfr_addr == ADDR_EXT_B)
        ext_b_r <= sfr_wdata;
      if (sfr_addr == ADDR_AUX_CTRL)
        aux_ctrl_r <= sfr_wdata;
    end
  end

  // Read data, unmapped addresses read zero
  always_comb
  begin
    case (sfr_addr)
      ADDR_EXT_ACC: sfr_rdata_r = ext_acc_r;
      ADDR_EXT_ACC2: sfr_rdata_r = ext_acc2_r;
      ADDR_EXT_ACC3: sfr_rdata_r = ext_acc3_r;
      ADDR_EXT_B: sfr_rdata_r = ext_b_r;
      ADDR_AUX_CTRL: sfr_rdata_r = aux_ctrl_r;
      default: sfr_rdata_r = 8'h00;
    endcase
  end

  // Core-facing results and stall
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sfr_rdata <= 8'h00;
      acc_out_r <= 8'h00;
      b_out_r <= 8'h00;
      ov_r <= 1'b0;
      result_wr_r <= 1'b0;
      stall_r <= 1'b0;
    end
    else if (ce)
    begin
      sfr_rdata <= sfr_rdata_r;
      result_wr_r <= finish;
      if (take)
      begin
        stall_r <= 1'b1;
      end
      else if (finish)
      begin
        stall_r <= 1'b0;
        acc_out_r <= res_acc;
        b_out_r <= res_b;
        ov_r <= res_ov;
      end
    end
  end

  assign acc_out = acc_out_r;
  assign b_out = b_out_r;
  assign ov_out = ov_r;
  assign result_wr = result_wr_r;
  assign stall = stall_r;

endmodule
`default_nettype wire

// [verification/wmdu_core_model.sv]
// Core-side model that offers multiply and divide opcodes to the unit.
// Assumes the bench calls issue between clock edges while ce is high.
`timescale 1ns/1ps
`default_nettype none
module wmdu_core_model
(
  input wire logic clk_sys,
  input wire logic stall,
  output logic op_valid,
  output logic [7:0] op_code,
  output logic [7:0] acc_in,
  output logic [7:0] b_in
);
  initial
  begin
    op_valid = 1'b0;
    op_code = 8'h00;
    acc_in = 8'h00;
    b_in = 8'h00;
  end
  // One-cycle request, then released operands change
  always @(negedge clk_sys)
    if (op_valid)
    begin
      op_valid <= 1'b0;
      op_code <= ~op_code;
      acc_in <= ~acc_in;
      b_in <= ~b_in;
    end
  task automatic issue(input logic [7:0] opc, input logic [7:0] a, input logic [7:0] b,
                       output bit ok);
    int i;
    ok = 0;
    for (i = 0; i < 100 && !ok; i++)
    begin
      @(negedge clk_sys);
      ok = !stall;
    end
    op_valid <= ok;
    op_code <= opc;
    acc_in <= a;
    b_in <= b;
  endtask
endmodule
`default_nettype wire

// [verification/wmdu_top_monitor.sv]
// Checker for the wide multiply/divide unit.
// Assumes aux writes and opcodes are not offered in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module wmdu_monitor
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] b_in,
  input wire logic [7:0] acc_out,
  input wire logic [7:0] b_out,
  input wire logic ov_out,
  input wire logic result_wr,
  input wire logic stall
);
  import wmdu_pkg::*;
  logic take;
  logic [7:0] aux_r, a_c, b_c, op_c, aux_c;
  assign take = ce && op_valid && !stall && (op_code == OPC_MUL || op_code == OPC_DIV);
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      aux_r <= RST_AUX_CTRL;
      a_c <= 8'h00;
      b_c <= 8'h00;
      op_c <= 8'h00;
      aux_c <= 8'h00;
    end
    else
    begin
      if (ce && sfr_wr && !stall && sfr_addr == ADDR_AUX_CTRL)
        aux_r <= sfr_wdata;
      if (take)
      begin
        a_c <= acc_in;
        b_c <= b_in;
        op_c <= op_code;
        aux_c <= aux_r;
      end
    end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  lat_eight_a: assert property (take && !aux_r[0] |-> ##10 result_wr)
    else $error("classic latency wrong");
  mul_wide_a: assert property (take && aux_r[0] && op_code == OPC_MUL |-> ##18 result_wr)
    else $error("wide multiply latency wrong");
  div_wide_a: assert property (take && aux_r[0] && !aux_r[3] && op_code == OPC_DIV |-> ##18 result_wr)
    else $error("wide divide latency wrong");
  div_long_a: assert property (take && aux_r[0] && aux_r[3] && op_code == OPC_DIV |-> ##34 result_wr)
    else $error("long divide latency wrong");
  stall_run_a: assert property (take |=> (stall && !result_wr) [*8])
    else $error("stall dropped early");
  mul_byte_a: assert property (result_wr && !aux_c[0] && op_c == OPC_MUL |->
    {b_out, acc_out} == a_c * b_c && ov_out == (a_c * b_c > 16'h00FF))
    else $error("byte product wrong");
  div_byte_a: assert property (result_wr && !aux_c[0] && op_c == OPC_DIV && b_c != 8'h00 |->
    acc_out == a_c / b_c && b_out == a_c % b_c && !ov_out)
    else $error("byte quotient wrong");
  div_zero_a: assert property (result_wr && !aux_c[0] && op_c == OPC_DIV && b_c == 8'h00 |-> ov_out)
    else $error("zero divisor flag missing");
  wr_pulse_a: assert property (result_wr |=> !result_wr)
    else $error("result strobe too long");
  cover property (take && aux_r[0] && aux_r[3] && op_code == OPC_DIV);
  cover property (take && !aux_r[0] && aux_r[3]);
  cover property (result_wr && ov_out);
endmodule
bind wmdu_top wmdu_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .ce(ce), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .op_valid(op_valid), .op_code(op_code),
  .acc_in(acc_in), .b_in(b_in), .acc_out(acc_out), .b_out(b_out), .ov_out(ov_out),
  .result_wr(result_wr), .stall(stall));
`default_nettype wire

// [verification/wmdu_top_tb_top.sv]
// Self-checking bench for the wide multiply/divide unit.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module wide_mul_div_unit_tb_top;
  import wmdu_pkg::*;
  logic clk_sys = 0, rst = 1, ce = 1, sfr_wr = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, acc_out, b_out, op_code, acc_in, b_in;
  logic ov_out, result_wr, stall, op_valid;
  logic [7:0] v;
  logic [7:0] modes [4] = '{8'h00, 8'h01, 8'h09, 8'h08};
  int bad_count = 0, checks = 0, k;
  integer seed = 75;
  initial
    forever #12.5 clk_sys = ~clk_sys;
  wmdu_top u_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .op_valid(op_valid), .op_code(op_code),
    .acc_in(acc_in), .b_in(b_in), .acc_out(acc_out), .b_out(b_out), .ov_out(ov_out),
    .result_wr(result_wr), .stall(stall));
  wmdu_core_model u_core (.clk_sys(clk_sys), .stall(stall), .op_valid(op_valid),
    .op_code(op_code), .acc_in(acc_in), .b_in(b_in));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(negedge clk_sys);
    sfr_wr = 0;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    @(negedge clk_sys);
    d = sfr_rdata;
  endtask
  task automatic run(logic [7:0] aux, logic [7:0] opc, logic [31:0] x, logic [15:0] y);
    logic [31:0] p, q, r;
    logic [47:0] e;
    logic [7:0] rv;
    bit ok, mul, dz;
    int n;
    mul = (opc == OPC_MUL);
    wr(ADDR_AUX_CTRL, aux);
    wr(ADDR_EXT_ACC, x[15:8]);
    wr(ADDR_EXT_ACC2, x[23:16]);
    wr(ADDR_EXT_ACC3, x[31:24]);
    wr(ADDR_EXT_B, y[15:8]);
    u_core.issue(opc, x[7:0], y[7:0], ok);
    if (!ok)
    begin
      bad_count++;
      finish_test;
    end
    @(posedge clk_sys);
    for (n = 1; n < 100; n++)
    begin
      @(posedge clk_sys);
      #1;
      if (result_wr === 1'b1)
        break;
    end
    if (n == 100)
    begin
      bad_count++;
      finish_test;
    end
    if (!aux[0])
    begin
      p = x[7:0] * y[7:0];
      q = x[7:0] / y[7:0];
      r = x[7:0] % y[7:0];
      e = mul ? {p[7:0], p[15:8], 32'h0} : {q[7:0], r[7:0], 32'h0};
      dz = !mul && y[7:0] == 8'h00;
      check("latency", n, STEPS_8 + 1);
      check("ov", ov_out, mul ? p[15:8] != 0 : dz);
    end
    else
    begin
      p = x[15:0] * y;
      q = aux[3] ? x / y : x[15:0] / y;
      r = aux[3] ? x % y : x[15:0] % y;
      e = mul ? {p[15:8], p[23:16], p[7:0], p[31:24], 16'h0} :
        {q[31:24], r[15:8], q[23:16], r[7:0], q[15:8], q[7:0]};
      if (!aux[3] && !mul)
        e[47:24] = {q[15:8], r[15:8], q[7:0]};
      dz = !mul && y == 16'h0000;
      check("latency", n, (aux[3] && !mul) ? STEPS_32 + 1 : STEPS_16 + 1);
      check("ov", ov_out, mul ? p[31:16] != 0 : dz);
    end
    if (!dz)
      check("acc_b", {acc_out, b_out}, e[47:32]);
    if (aux[0] && !dz)
    begin
      rd(ADDR_EXT_ACC, rv);
      check("ext_acc", rv, e[31:24]);
      rd(ADDR_EXT_B, rv);
      check("ext_b", rv, e[23:16]);
      if (aux[3] && !mul)
      begin
        rd(ADDR_EXT_ACC2, rv);
        check("ext_acc2", rv, e[15:8]);
        rd(ADDR_EXT_ACC3, rv);
        check("ext_acc3", rv, e[7:0]);
      end
    end
    $display("test done aux %h op %h", aux, opc);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 0;
    foreach (modes[i])
    begin
      rd(i == 0 ? ADDR_AUX_CTRL : i == 1 ? ADDR_EXT_ACC : i == 2 ? ADDR_EXT_B : 8'h00, v);
      check("reset_or_unmapped", v, 8'h00);
    end
    run(8'h00, OPC_MUL, 32'hFF, 16'hFF);
    run(8'h08, OPC_DIV, 32'h64, 16'h07);
    run(8'h00, OPC_DIV, 32'h12, 16'h00);
    run(8'h01, OPC_MUL, 32'hFFFF, 16'hFFFF);
    run(8'h01, OPC_DIV, 32'h1234, 16'h0000);
    run(8'h09, OPC_DIV, 32'hFFFFFFFF, 16'h0001);
    for (k = 0; k < 40; k++)
      run(modes[$random(seed) & 3], ($random(seed) & 1) ? OPC_MUL : OPC_DIV,
        $random(seed), $random(seed) >> (($random(seed) & 1) * 12));
    finish_test;
  end
endmodule
`default_nettype wire
